//--- rtl/cog_pkg.sv
// Constants and types for the clock output gating control block.
// Assumes a single 40 MHz system clock; all other rates come as enables.
`default_nettype none
package cog_pkg;
    localparam int NUM_OUT     = 3;
    localparam int DIV_W       = 16;
    localparam int DEV_W       = 5;
    localparam int RATE_W      = 8;
    localparam int SETTLE_NS   = 1000;
    localparam int CLK_NS      = 25;
    localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 16;
    localparam logic [1:0] IDX_A = 2'h0;
    localparam logic [1:0] IDX_B = 2'h1;
    localparam logic [1:0] IDX_C = 2'h2;
    typedef enum logic [1:0] {
        COG_OFF    = 2'b00,
        COG_LOCK   = 2'b01,
        COG_SETTLE = 2'b11,
        COG_RUN    = 2'b10
    } cog_state_e;
    typedef enum logic {
        COG_SPREAD_CENTER = 1'b0,
        COG_SPREAD_DOWN   = 1'b1
    } cog_spread_e;
    typedef struct packed {
        logic                          input_is_xtal;
        logic                          diff_mode;
        logic        [NUM_OUT-1:0]     bypass;
        logic        [NUM_OUT-1:0]     invert;
        logic        [DIV_W-1:0]       divide;
        logic                          spread_on;
        cog_spread_e                   spread_type;
        logic        [DEV_W-1:0]       spread_dev;
        logic        [RATE_W-1:0]      spread_rate;
    } cog_cfg_s;
endpackage : cog_pkg
`default_nettype wire

//--- rtl/cog_cfg_if.sv
// Interface carrying the applied configuration from store to output logic.
// Assumes both ends run on the same system clock.
`default_nettype none
interface cog_cfg_if;
    import cog_pkg::*;
    cog_cfg_s cfg;
    logic     locked_cfg;
    modport store (output cfg, output locked_cfg);
    modport user  (input cfg, input locked_cfg);
endinterface : cog_cfg_if
`default_nettype wire

//--- rtl/cog_cfg_store.sv
// One-time programmable configuration store.
// Assumes host writes arrive as one-cycle strobes from the serial front end.
`default_nettype none
module cog_cfg_store
    import cog_pkg::*;
(
    input  wire logic     i_clock,
    input  wire logic     i_rst_n,
    input  wire logic     i_wr,
    input  wire cog_cfg_s i_wr_cfg,
    input  wire logic     i_burn,
    cog_cfg_if.store      cfg_if
);
    import cog_pkg::*;
    logic burned_q;
    cog_cfg_s cfg_q;

    // Volatile image follows writes until burned; after that only reset changes it, clearing it to zero
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            cfg_q <= '0;
        end
        else if (i_wr && !burned_q)
        begin
            cfg_q <= i_wr_cfg;
        end
    end

    // Fuse flag survives reset; models a blown fuse that cannot be undone
    always_ff @(posedge i_clock)
    begin
        if (i_burn)
        begin
            burned_q <= 1'b1;
        end
        else if (burned_q !== 1'b1)
        begin
            burned_q <= 1'b0;
        end
    end

    assign cfg_if.cfg        = cfg_q;
    assign cfg_if.locked_cfg = burned_q;
endmodule : cog_cfg_store
`default_nettype wire

//--- rtl/cog_out_gate.sv
// One clock output lane: source pick, inversion and glitch-free gating.
// Assumes the enable is already synchronised to the system clock.
`default_nettype none
module cog_out_gate (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_pll_clk,
    input  wire logic i_ref_clk,
    input  wire logic i_bypass,
    input  wire logic i_invert,
    input  wire logic i_allow,
    output var  logic o_clk
);
    logic run_q;
    logic src;
    assign src = (i_bypass ? i_ref_clk : i_pll_clk) ^ i_invert;

    // Enable only moves while the source is low, so no pulse is cut short
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            run_q <= 1'b0;
        end
        else if (!src)
        begin
            run_q <= i_allow;
        end
    end

    // Registered output; rests low while gated
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_clk <= 1'b0;
        end
        else
        begin
            o_clk <= run_q & src;
        end
    end
endmodule : cog_out_gate
`default_nettype wire

//--- rtl/cog_top.sv
// Top of the clock output gating control: power-down, lock wait, enables,
// divider, spread modulation and the three output lanes.
// Assumes pins arrive asynchronously and are synchronised here.
`default_nettype none
module cog_top
    import cog_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    input  wire logic               i_clock,
    input  wire logic               i_rst_n,
    input  wire logic               i_powerdown_pin_n,
    input  wire logic [NUM_OUT-1:0] i_enable_pin,
    input  wire logic               i_pll_lock,
    input  wire logic               i_ref_input,
    input  wire logic               i_xtal_osc,
    input  wire logic               i_vco_clk,
    input  wire logic               i_cfg_wr,
    input  wire cog_cfg_s           i_cfg_data,
    input  wire logic               i_cfg_burn,
    output logic                    o_clock_out_a,
    output logic                    o_clock_out_b,
    output logic                    o_clock_out_c,
    output logic                    o_crystal_drive_en,
    output logic                    o_pll_enable,
    output logic [DEV_W-1:0]        o_spread_offset,
    output logic                    o_spread_down,
    output logic                    o_cfg_burned,
    output logic                    o_running
);
    import cog_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [NUM_OUT+3:0] s1_q;
    logic [NUM_OUT+3:0] s2_q;
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= {i_xtal_osc, i_ref_input, i_pll_lock, i_powerdown_pin_n, i_enable_pin};
            s2_q <= s1_q;
        end
    end
    logic [NUM_OUT-1:0] en_s;
    logic pd_n_s, lock_s, ref_s, xtal_s;
    assign en_s   = s2_q[NUM_OUT-1:0];
    assign pd_n_s = s2_q[NUM_OUT];
    assign lock_s = s2_q[NUM_OUT+1];
    assign ref_s  = s2_q[NUM_OUT+2];
    assign xtal_s = s2_q[NUM_OUT+3];

    ////////////////////////////////////////////////////////////////////////
    // Configuration store
    cog_cfg_if cfg_if ();
    cog_cfg_store u_store (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_wr     (i_cfg_wr),
        .i_wr_cfg (i_cfg_data),
        .i_burn   (i_cfg_burn),
        .cfg_if   (cfg_if.store)
    );
    cog_cfg_s cfg;
    assign cfg = cfg_if.cfg;

    ////////////////////////////////////////////////////////////////////////
    // Power state: off, wait for lock, settle, run
    cog_state_e st_q;
    logic [CNT_W-1:0] settle_q;
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n || !pd_n_s)
        begin
            st_q     <= COG_OFF;
            settle_q <= '0;
        end
        else
        begin
            case (st_q)
                COG_OFF:
                begin
                    st_q <= COG_LOCK;
                end
                COG_LOCK:
                begin
                    settle_q <= '0;
                    if (lock_s)
                    begin
                        st_q <= COG_SETTLE;
                    end
                end
                COG_SETTLE:
                begin
                    // Lock loss restarts the wait; frequency not yet trusted
                    if (!lock_s)
                    begin
                        st_q <= COG_LOCK;
                    end
                    else if (settle_q == CNT_W'(SETTLE - 1))
                    begin
                        st_q <= COG_RUN;
                    end
                    else
                    begin
                        settle_q <= settle_q + 1'b1;
                    end
                end
                COG_RUN:
                begin
                    if (!lock_s)
                    begin
                        st_q <= COG_LOCK;
                    end
                end
                default:
                begin
                    st_q <= COG_OFF;
                end
            endcase
        end
    end
    logic running;
    assign running = (st_q == COG_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Input source and output divider
    logic in_clk;
    assign in_clk = cfg.input_is_xtal ? xtal_s : ref_s;
    logic [DIV_W-1:0] div_q;
    logic pll_q;
    logic [DIV_W-1:0] div_lim;
    // Spread lengthens or wobbles the period; bypassed lanes never see it
    assign div_lim = cfg.divide + DIV_W'(o_spread_offset);
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n || !running)
        begin
            div_q <= '0;
            pll_q <= 1'b0;
        end
        else if (div_q >= div_lim)
        begin
            div_q <= '0;
            pll_q <= ~pll_q;
        end
        else
        begin
            div_q <= div_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Spread modulation: triangle offset stepped at the rate enable
    logic [RATE_W-1:0] rate_q;
    logic [DEV_W-1:0]  tri_q;
    logic              up_q;
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n || !cfg.spread_on)
        begin
            rate_q <= '0;
            tri_q  <= '0;
            up_q   <= 1'b1;
        end
        else if (rate_q >= cfg.spread_rate)
        begin
            rate_q <= '0;
            if (up_q && tri_q >= cfg.spread_dev)
            begin
                up_q <= 1'b0;
            end
            else if (!up_q && tri_q == '0)
            begin
                up_q <= 1'b1;
            end
            else
            begin
                tri_q <= up_q ? tri_q + 1'b1 : tri_q - 1'b1;
            end
        end
        else
        begin
            rate_q <= rate_q + 1'b1;
        end
    end
    // Down spread only stretches; center spread offset is centred by host choice of divide
    assign o_spread_offset = tri_q;
    assign o_spread_down   = cfg.spread_type == COG_SPREAD_DOWN;

    ////////////////////////////////////////////////////////////////////////
    // Output lanes
    logic [NUM_OUT-1:0] allow;
    logic [NUM_OUT-1:0] lane;
    // In differential mode both halves follow output b's enable
    assign allow[IDX_A] = running & (cfg.diff_mode ? en_s[IDX_B] : en_s[IDX_A]);
    assign allow[IDX_B] = running & en_s[IDX_B];
    assign allow[IDX_C] = running & en_s[IDX_C];
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++)
        begin : g_lane
            cog_out_gate u_gate (
                .i_clock   (i_clock),
                .i_rst_n   (i_rst_n & pd_n_s),
                .i_pll_clk (pll_q),
                .i_ref_clk (in_clk),
                .i_bypass  (cfg.bypass[g]),
                .i_invert  (cfg.invert[g]),
                .i_allow   (allow[g]),
                .o_clk     (lane[g])
            );
        end
    endgenerate

    // Differential: a is complement of b; when gated b rests low and a rests high
    always_comb
    begin
        o_clock_out_b = pd_n_s & lane[IDX_B];
        o_clock_out_c = pd_n_s & lane[IDX_C];
        if (cfg.diff_mode)
        begin
            o_clock_out_a = pd_n_s & ~lane[IDX_B];
        end
        else
        begin
            o_clock_out_a = pd_n_s & lane[IDX_A];
        end
    end

    assign o_crystal_drive_en = pd_n_s & cfg.input_is_xtal;
    assign o_pll_enable       = pd_n_s & (st_q != COG_OFF);
    assign o_cfg_burned       = cfg_if.locked_cfg;
    // Gated by the synced pin so power-down shows at once, like the lanes
    assign o_running          = pd_n_s & running;
endmodule : cog_top
`default_nettype wire

//--- verif/cog_top_properties.sv
// Checker for the gating control top: power-down, lock wait, lane gating, fuse.
// Assumes it is bound into cog_top and sees only that module's ports.
`default_nettype none
module cog_top_properties
    import cog_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    input wire logic         i_clock,
    input wire logic         i_rst_n,
    input wire logic         i_powerdown_pin_n,
    input wire logic [2:0]   i_enable_pin,
    input wire logic         i_pll_lock,
    input wire logic         i_cfg_burn,
    input wire logic         o_clock_out_a,
    input wire logic         o_clock_out_b,
    input wire logic         o_clock_out_c,
    input wire logic         o_pll_enable,
    input wire logic         o_cfg_burned,
    input wire logic         o_running,
    input wire logic         o_crystal_drive_en
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // Power-down wins over everything once it has crossed the synchroniser
    pd_outs_low_a: assert property (!i_powerdown_pin_n [*3] |->
        !(o_clock_out_a | o_clock_out_b | o_clock_out_c)) else $error("output while down");
    pd_core_off_a: assert property (!i_powerdown_pin_n [*3] |->
        !o_pll_enable && !o_running && !o_crystal_drive_en) else $error("core on while down");
    pd_prompt_a: assert property ($fell(i_powerdown_pin_n) |->
        ##[0:3] !o_pll_enable) else $error("slow power-down");
    // Run state only after lock and the full settle wait
    run_settle_a: assert property ($rose(o_running) |->
        $past(o_pll_enable, SETTLE) && $past(i_pll_lock, 2)) else $error("early run");
    se_wait_lock_a: assert property (($rose(o_clock_out_b) || $rose(o_clock_out_c)) |->
        $past(o_running)) else $error("edge before run");
    // Lane c opens only after its enable pin was seen high
    en_gate_c_a: assert property ($rose(o_clock_out_c) |->
        ($past(i_enable_pin[2], 2) || $past(i_enable_pin[2], 3) || $past(i_enable_pin[2], 4)))
        else $error("lane c edge while disabled");
    // The fuse can be set but never cleared
    burn_sticks_a: assert property (o_cfg_burned |=> o_cfg_burned) else $error("fuse cleared");
    burn_takes_a: assert property (i_cfg_burn |=> o_cfg_burned) else $error("fuse not set");
endmodule : cog_top_properties

bind cog_top cog_top_properties #(.SETTLE(SETTLE)) cog_top_properties_i (
    .i_clock, .i_rst_n, .i_powerdown_pin_n, .i_enable_pin, .i_pll_lock, .i_cfg_burn,
    .o_clock_out_a, .o_clock_out_b, .o_clock_out_c, .o_pll_enable, .o_cfg_burned,
    .o_running, .o_crystal_drive_en
);
`default_nettype wire

//--- verif/cog_far_model.sv
// Far side model: reference clock, crystal oscillator and analog lock flag.
// Assumes the bench clock; lock follows the allow input after a fixed delay.
`default_nettype none
module cog_far_model #(
    parameter int LOCK_DLY = 6
) (
    input  wire logic i_clock,
    input  wire logic i_allow,
    output var  logic o_ref,
    output var  logic o_xtal,
    output var  logic o_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q = 0;
    int div_q = 0;
    initial o_ref = 1'b0;
    initial o_xtal = 1'b0;
    initial o_lock = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Two unrelated source rates so a wrong source pick would show
    always @(posedge i_clock)
    begin
        div_q <= div_q + 1;
        if (div_q % 2 == 1) o_ref <= ~o_ref;
        if (div_q % 3 == 2) o_xtal <= ~o_xtal;
    end
    // Lock drops at once when not allowed, like a real loop losing its input
    always @(posedge i_clock)
    begin
        cnt_q <= i_allow ? ((cnt_q < LOCK_DLY) ? cnt_q + 1 : cnt_q) : 0;
        o_lock <= i_allow && (cnt_q == LOCK_DLY);
    end
endmodule : cog_far_model
`default_nettype wire

//--- verif/clock_output_gating_control_bench.sv
// Self-checking bench for cog_top with the far side model.
// Assumes cog_top, cog_pkg and the bound checker are compiled first.
`default_nettype none
module clock_output_gating_control_bench;
    import cog_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SET = 4;  // Short settle wait keeps the run small
    logic i_clock = 1'b0, i_rst_n = 1'b0, pd_n = 1'b0, allow = 1'b0, wr = 1'b0, burn = 1'b0;
    logic [2:0] en = 3'h7;
    cog_cfg_s cfg = '0;
    logic refc, xtal, lock, ca, cb, cc, xen, pll, down, burned, run;
    logic [DEV_W-1:0] offs;
    int n_mismatch = 0;
    int tests_run = 0;
    int ra, rb, rc;

    cog_far_model cog_far_model_i (.i_clock(i_clock), .i_allow(allow), .o_ref(refc),
        .o_xtal(xtal), .o_lock(lock));
    cog_top #(.SETTLE(SET)) cog_top_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_powerdown_pin_n(pd_n), .i_enable_pin(en), .i_pll_lock(lock), .i_ref_input(refc),
        .i_xtal_osc(xtal), .i_vco_clk(1'b0), .i_cfg_wr(wr), .i_cfg_data(cfg),
        .i_cfg_burn(burn), .o_clock_out_a(ca), .o_clock_out_b(cb), .o_clock_out_c(cc),
        .o_crystal_drive_en(xen), .o_pll_enable(pll), .o_spread_offset(offs),
        .o_spread_down(down), .o_cfg_burned(burned), .o_running(run));

    initial forever #12.5 i_clock = ~i_clock;
    ////////////////////////////////////////////////////////////////////////////
    // Waits n edges, then lets their updates settle before sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : cyc
    task automatic check(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check
    // Counts rising edges of the three lanes over n cycles
    task automatic rises(input int n);
        logic pa, pb, pc;
        ra = 0; rb = 0; rc = 0;
        repeat (n)
        begin
            pa = ca; pb = cb; pc = cc;
            cyc(1);
            ra += int'(!pa && ca); rb += int'(!pb && cb); rc += int'(!pc && cc);
        end
    endtask : rises
    task automatic wait_run();
        int k;
        k = 0;
        while (run !== 1'b1 && k < 300)
        begin
            cyc(1);
            k++;
        end
        check("running", 1'b1, run);
    endtask : wait_run
    ////////////////////////////////////////////////////////////////////////////
    // One configuration write, request held over one sampling edge
    task automatic put_cfg(input cog_cfg_s c);
        @(posedge i_clock)
        begin
            cfg <= c;
            wr  <= 1'b1;
        end
        @(posedge i_clock) wr <= 1'b0;
    endtask : put_cfg
    task automatic t_quiet();
        @(posedge i_clock) pd_n <= 1'b1;
        cyc(30);
        check("running before lock", 1'b0, run);
        rises(40);
        check("no edges before lock", 1'b1, ra + rb + rc == 0);
    endtask : t_quiet
    task automatic t_lock();
        @(posedge i_clock) allow <= 1'b1;
        wait_run();
        rises(40);
        check("all lanes run", 1'b1, ra > 0 && rb > 0 && rc > 0);
    endtask : t_lock
    // Differential pair, then bypass with inversion, then spread on top
    task automatic t_diff();
        cog_cfg_s c;
        c = '0;
        c.diff_mode = 1'b1;
        put_cfg(c);
        @(posedge i_clock) en <= 3'h6;
        cyc(10);
        rises(40);
        check("pair ignores a pin", 1'b1, ra > 0 && rb > 0);
        check("pair complementary", 1'b1, ca != cb);
        @(posedge i_clock) en <= 3'h5;
        cyc(10);
        check("pair rest high", 1'b1, ca);
        check("pair rest low", 1'b0, cb);
        @(posedge i_clock) en <= 3'h7;
        c.diff_mode = 1'b0;
        c.bypass[IDX_C] = 1'b1;
        c.invert[IDX_C] = 1'b1;
        put_cfg(c);
        cyc(10);
        rises(40);
        check("bypass rate", 1'b1, rc >= 9 && rc <= 11);
        check("pll rate", 1'b1, rb >= 19 && rb <= 21);
        c.spread_on = 1'b1;
        c.spread_type = COG_SPREAD_DOWN;
        c.spread_dev = 5'h03;
        c.spread_rate = 8'h00;
        put_cfg(c);
        cyc(10);
        rises(40);
        check("spread slows pll", 1'b1, rb > 0 && rb < 19);
        check("bypass unspread", 1'b1, rc >= 9 && rc <= 11);
        check("spread down", 1'b1, down);
        check("spread bound", 1'b1, offs <= 5'h03);
    endtask : t_diff
    // Each pin in turn: its own lane must stop, resting low, while at least one lane still runs
    task automatic t_enable();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge i_clock) en <= ~(3'h1 << i);
            cyc(10);
            rises(40);
            check("own lane stops", 1'b1, (i == 0 ? ra : i == 1 ? rb : rc) == 0);
            check("others run", 1'b1, ra + rb + rc > 0);
            check("disabled rests low", 1'b0, i == 0 ? ca : i == 1 ? cb : cc);
            @(posedge i_clock) en <= 3'h7;
        end
    endtask : t_enable
    task automatic t_pd();
        @(posedge i_clock) pd_n <= 1'b0;
        cyc(4);
        check("pll off", 1'b0, pll);
        check("not running", 1'b0, run);
        rises(20);
        check("outputs held low", 1'b1, ra + rb + rc == 0);
        @(posedge i_clock) pd_n <= 1'b1;
        wait_run();
    endtask : t_pd
    // A write after the fuse is set must be ignored, and the fuse must stay set across reset
    task automatic t_burn();
        @(posedge i_clock) burn <= 1'b1;
        @(posedge i_clock) burn <= 1'b0;
        cyc(2);
        check("fuse set", 1'b1, burned);
        @(posedge i_clock)
        begin
            cfg.input_is_xtal <= 1'b1;
            wr                <= 1'b1;
        end
        @(posedge i_clock) wr <= 1'b0;
        cyc(3);
        check("late write refused", 1'b0, xen);
        @(posedge i_clock) i_rst_n <= 1'b0;
        @(posedge i_clock) i_rst_n <= 1'b1;
        cyc(2);
        check("fuse kept over reset", 1'b1, burned);
    endtask : t_burn
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(8);
        @(posedge i_clock) i_rst_n <= 1'b1;
        t_quiet();
        t_lock();
        t_enable();
        t_pd();
        t_diff();
        t_burn();
        report_and_stop();
    end
    // Whole sequence needs about 500 cycles
    initial
    begin
        #(25 * 20000);
        n_mismatch++;
        report_and_stop();
    end
endmodule : clock_output_gating_control_bench
`default_nettype wire
